// file: src/rail_enable_fault_supervisor.sv
`timescale 1ns/1ns
module rail_enable_fault_supervisor #(
	parameter int OC_RESTART_CYCLES = supv_pkg::OC_RESTART_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire supv_pkg::bus_req_t bus,
	output logic [7:0] rdata_q,
	// pins and monitors from outside the clock domain
	input wire logic chip_en,
	input wire logic [3:0] gpio_in,
	input wire supv_pkg::monitor_t mon,
	// controls to the regulators and drivers
	output logic config_ready_q,
	output logic [2:0] ch_en_q,
	output logic ldo_on_q,
	output logic ldo_sel5v_q,
	output logic prog_dt_q,
	output logic builtin_nonoverlap_q,
	output supv_pkg::gap_t [2:0] gaps_q,
	output logic dt_step_q,
	output logic uv_warn_pin_q
);
	import supv_pkg::*;

	localparam int SYNC_W = 20;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [SYNC_W-1:0] s1_q;
	logic [SYNC_W-1:0] s2_q;
	logic en_s;
	logic [3:0] gpio_s;
	logic ot_s;
	logic [2:0] ov_s;
	logic [2:0] oc_s;
	logic [7:0] vin_s;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {chip_en, gpio_in, mon.ot, mon.ov, mon.oc, mon.vin};
			s2_q <= s1_q;
		end
	end

	// the input voltage code may tear on a change; it is a slow monitor value
	assign {en_s, gpio_s, ot_s, ov_s, oc_s, vin_s} = s2_q;

	// ----------------------------------------
	// state, soft reset and bus qualification
	// ----------------------------------------
	state_t st_q;
	logic soft_q;
	logic rst_all;
	logic wr_ok;
	logic rd_ok;
	logic run;
	logic [7:0] cfg_q [NCFG];

	assign rst_all = !rst_n || soft_q;
	assign run = st_q == ST_RUN;
	assign wr_ok = bus.wr && config_ready_q;
	assign rd_ok = bus.rd && config_ready_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			soft_q <= 1'b0;
		end else begin
			soft_q <= wr_ok && bus.addr == A_CMD && bus.wdata == RESTART_KEY;
		end
	end

	// enable is only looked at after the load, so a late core supply cannot
	// corrupt the copied configuration
	always_ff @(posedge clk) begin
		if (rst_all) begin
			st_q <= ST_LOAD;
		end else begin
			case (st_q)
				ST_LOAD: begin
					st_q <= ST_OFF;
				end
				ST_OFF: begin
					if (en_s) begin
						st_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (!en_s) begin
						st_q <= ST_OFF;
					end
				end
				default: begin
					st_q <= ST_LOAD;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst_all) begin
			config_ready_q <= 1'b0;
		end else begin
			config_ready_q <= run && en_s;
		end
	end

	// ----------------------------------------
	// one-time-programmable store
	// ----------------------------------------
	// a programmed bit is a one; clearing one back is refused whole,
	// the store survives the host restart and only power-on clears it
	logic [7:0] otp_q [NCFG];
	logic [3:0] otp_idx_q;
	logic refused_q;
	logic otp_wr;

	assign otp_wr = wr_ok && bus.addr == A_OTP_PROG && otp_idx_q < NCFG_A[3:0];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int k = 0; k < NCFG; k++) begin
				otp_q[k] <= OTP_BLANK;
			end
		end else if (otp_wr && (otp_q[otp_idx_q] & ~bus.wdata) == 8'h00) begin
			otp_q[otp_idx_q] <= otp_q[otp_idx_q] | bus.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst_all) begin
			refused_q <= 1'b0;
		end else if (otp_wr && (otp_q[otp_idx_q] & ~bus.wdata) != 8'h00) begin
			refused_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst_all) begin
			otp_idx_q <= 4'h0;
		end else if (wr_ok && bus.addr == A_OTP_IDX) begin
			otp_idx_q <= bus.wdata[3:0];
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int k = 0; k < NCFG; k++) begin
				cfg_q[k] <= CFG_RST;
			end
		end else if (st_q == ST_LOAD) begin
			for (int k = 0; k < NCFG; k++) begin
				cfg_q[k] <= otp_q[k];
			end
		end else if (wr_ok && bus.addr < NCFG_A) begin
			cfg_q[bus.addr[3:0]] <= bus.wdata;
		end
	end

	// ----------------------------------------
	// input voltage and temperature monitoring
	// ----------------------------------------
	logic uv_warn;
	logic uv_hit;
	logic uv_f_q;
	logic ot_f_q;
	logic [7:0] ff_clr;

	assign uv_warn = vin_s <= cfg_q[I_WARN];
	assign uv_hit = vin_s <= cfg_q[I_FAULT];
	assign ff_clr = (wr_ok && bus.addr == A_FFLAG) ? bus.wdata : 8'h00;

	// a new trip in the cycle of a clear wins over the clear
	always_ff @(posedge clk) begin
		if (rst_all) begin
			uv_f_q <= 1'b0;
		end else if (run && uv_hit) begin
			uv_f_q <= 1'b1;
		end else if (ff_clr[FF_UV] || (cfg_q[I_GCTL][GCTL_UV_AUTO] && !uv_warn)) begin
			uv_f_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst_all) begin
			uv_warn_pin_q <= 1'b0;
		end else begin
			uv_warn_pin_q <= run && uv_warn;
		end
	end

	always_ff @(posedge clk) begin
		if (rst_all) begin
			ot_f_q <= 1'b0;
		end else if (run && ot_s) begin
			ot_f_q <= 1'b1;
		end else if (ff_clr[FF_OT]) begin
			ot_f_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// per-channel faults and enables
	// ----------------------------------------
	function automatic logic src_on(input logic [1:0] src, input logic pin, input logic host);
		case (src)
			SRC_ALWAYS: src_on = 1'b1;
			SRC_PIN: src_on = pin;
			SRC_HOST: src_on = host;
			default: src_on = 1'b0;
		endcase
	endfunction

	logic [2:0] ov_f_q;
	logic [2:0] oc_f_q;

	for (genvar i = 0; i < 3; i++) begin : g_ch
		logic [OC_CNT_W-1:0] oc_cnt_q;

		// over-voltage stays off until the host clears the flag
		always_ff @(posedge clk) begin
			if (rst_all) begin
				ov_f_q[i] <= 1'b0;
			end else if (run && ov_s[i]) begin
				ov_f_q[i] <= 1'b1;
			end else if (ff_clr[FF_OV+i]) begin
				ov_f_q[i] <= 1'b0;
			end
		end

		always_ff @(posedge clk) begin
			if (rst_all) begin
				oc_f_q[i] <= 1'b0;
				oc_cnt_q <= '0;
			end else if (!oc_f_q[i]) begin
				oc_cnt_q <= '0;
				if (run && oc_s[i]) begin
					oc_f_q[i] <= 1'b1;
				end
			end else if (oc_cnt_q == OC_CNT_W'(OC_RESTART_CYCLES - 1)) begin
				oc_f_q[i] <= 1'b0;
				oc_cnt_q <= '0;
			end else begin
				oc_cnt_q <= oc_cnt_q + 1'b1;
			end
		end

		always_ff @(posedge clk) begin
			if (rst_all) begin
				ch_en_q[i] <= 1'b0;
			end else begin
				ch_en_q[i] <= run && en_s
					&& src_on(cfg_q[I_SRC][2*i +: 2], gpio_s[i], cfg_q[I_HOST_EN][i])
					&& !(uv_f_q || ot_f_q || ov_f_q[i] || oc_f_q[i]);
			end
		end

		always_ff @(posedge clk) begin
			if (rst_all) begin
				gaps_q[i] <= '0;
			end else begin
				gaps_q[i].lh <= cfg_q[I_LH0+i];
				gaps_q[i].hl <= cfg_q[I_HL0+i];
			end
		end
	end

	// ----------------------------------------
	// standby regulator
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst_all) begin
			ldo_on_q <= 1'b0;
			ldo_sel5v_q <= 1'b0;
		end else begin
			ldo_sel5v_q <= cfg_q[I_LDO][LDO_SEL5V];
			ldo_on_q <= (cfg_q[I_LDO][LDO_BY_EN] && en_s)
				|| (cfg_q[I_LDO][LDO_BY_PIN] && gpio_s[LDO_PIN])
				|| (cfg_q[I_LDO][LDO_BY_HOST] && cfg_q[I_LDO][LDO_HOST_ON]);
		end
	end

	// ----------------------------------------
	// dead time
	// ----------------------------------------
	// the switching period is DT_STEPS ticks of dt_step_q, so one gap unit
	// tracks the programmed frequency without a divider in the driver
	logic [7:0] step_div_q;
	logic [7:0] step_cnt_q;

	always_ff @(posedge clk) begin
		if (rst_all) begin
			prog_dt_q <= 1'b0;
			builtin_nonoverlap_q <= 1'b1;
		end else begin
			prog_dt_q <= cfg_q[I_GCTL][GCTL_PROG_DT];
			builtin_nonoverlap_q <= !cfg_q[I_GCTL][GCTL_PROG_DT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst_all) begin
			step_div_q <= STEP_DIV_RST;
		end else if (wr_ok && bus.addr == A_STEP_DIV) begin
			step_div_q <= bus.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst_all) begin
			step_cnt_q <= 8'h00;
			dt_step_q <= 1'b0;
		end else if (step_cnt_q >= step_div_q) begin
			step_cnt_q <= 8'h00;
			dt_step_q <= 1'b1;
		end else begin
			step_cnt_q <= step_cnt_q + 8'h01;
			dt_step_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst_all) begin
			rdata_q <= 8'h00;
		end else if (!rd_ok) begin
			rdata_q <= 8'h00;
		end else if (bus.addr < NCFG_A) begin
			rdata_q <= cfg_q[bus.addr[3:0]];
		end else begin
			case (bus.addr)
				A_VIN: rdata_q <= vin_s;
				A_WFLAG: rdata_q <= {7'h00, uv_warn_pin_q};
				A_FFLAG: rdata_q <= {oc_f_q, ov_f_q, ot_f_q, uv_f_q};
				A_STAT: rdata_q <= {2'h0, refused_q, ldo_on_q, ch_en_q, config_ready_q};
				A_OTP_IDX: rdata_q <= {4'h0, otp_idx_q};
				A_STEP_DIV: rdata_q <= step_div_q;
				default: rdata_q <= 8'h00;
			endcase
		end
	end

endmodule

// file: src/supv_pkg.sv
package supv_pkg;

	// ----------------------------------------
	// register map (8-bit data, 8-bit address)
	// ----------------------------------------
	// configuration registers sit at their own index 0..NCFG-1
	localparam int NCFG = 12;
	localparam logic [7:0] NCFG_A = 8'h0C;
	localparam int I_SRC = 0;
	localparam int I_HOST_EN = 1;
	localparam int I_LDO = 2;
	localparam int I_GCTL = 3;
	localparam int I_LH0 = 4;
	localparam int I_HL0 = 7;
	localparam int I_WARN = 10;
	localparam int I_FAULT = 11;
	localparam logic [7:0] A_VIN = 8'h0C;
	localparam logic [7:0] A_WFLAG = 8'h0D;
	localparam logic [7:0] A_FFLAG = 8'h0E;
	localparam logic [7:0] A_STAT = 8'h0F;
	localparam logic [7:0] A_CMD = 8'h10;
	localparam logic [7:0] A_OTP_IDX = 8'h11;
	localparam logic [7:0] A_OTP_PROG = 8'h12;
	localparam logic [7:0] A_STEP_DIV = 8'h13;

	// ----------------------------------------
	// field layouts and values
	// ----------------------------------------
	localparam logic [7:0] RESTART_KEY = 8'hA5;
	localparam logic [1:0] SRC_OFF = 2'h0;
	localparam logic [1:0] SRC_ALWAYS = 2'h1;
	localparam logic [1:0] SRC_PIN = 2'h2;
	localparam logic [1:0] SRC_HOST = 2'h3;
	localparam int LDO_SEL5V = 0;
	localparam int LDO_BY_EN = 1;
	localparam int LDO_BY_PIN = 2;
	localparam int LDO_BY_HOST = 3;
	localparam int LDO_HOST_ON = 4;
	localparam int GCTL_PROG_DT = 0;
	localparam int GCTL_UV_AUTO = 1;
	localparam int FF_UV = 0;
	localparam int FF_OT = 1;
	localparam int FF_OV = 2;
	localparam int FF_OC = 5;
	localparam int WF_UV = 0;
	localparam int ST_READY = 0;
	localparam int ST_CH = 1;
	localparam int ST_LDO = 4;
	localparam int ST_REFUSED = 5;
	localparam logic [7:0] OTP_BLANK = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] STEP_DIV_RST = 8'h03;
	localparam int DT_STEPS = 256;
	localparam int LDO_PIN = 3;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int OC_RESTART_MS = 200;
	localparam int OC_RESTART_CYC = OC_RESTART_MS * (CLK_HZ / 1000);
	localparam int OC_CNT_W = 23;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,
		ST_OFF = 2'b01,
		ST_RUN = 2'b10
	} state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		logic ot;
		logic [2:0] ov;
		logic [2:0] oc;
		logic [7:0] vin;
	} monitor_t;

	typedef struct packed {
		logic [7:0] lh;
		logic [7:0] hl;
	} gap_t;

endpackage

// file: sim/supv_sva.sv
`timescale 1ns/1ns
module supv_chk
	import supv_pkg::*;
(
	// watched ports
	input wire logic clk,
	input wire logic rst_n,
	input wire supv_pkg::bus_req_t bus,
	input wire logic [7:0] rdata_q,
	input wire logic chip_en,
	input wire supv_pkg::monitor_t mon,
	input wire logic config_ready_q,
	input wire logic [2:0] ch_en_q,
	input wire logic prog_dt_q,
	input wire logic builtin_nonoverlap_q,
	input wire supv_pkg::gap_t [2:0] gaps_q,
	input wire logic dt_step_q
);
	// ----------------
	// properties
	// ----------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	dt_mode_a: assert property (builtin_nonoverlap_q == !prog_dt_q)
		else $error("dead time mode pair broken");
	read_cause_a: assert property (rdata_q != 8'h00 |-> $past(bus.rd && config_ready_q))
		else $error("read data without accepted read");
	chip_off_a: assert property (!chip_en [*4] |=> ch_en_q == 3'h0)
		else $error("channel on while chip disabled");
	ready_drop_a: assert property (!chip_en [*4] |=> !config_ready_q)
		else $error("ready while chip disabled");
	heat_stop_a: assert property (mon.ot [*4] |=> ch_en_q == 3'h0)
		else $error("channel on during over temperature");
	volt_stop_a: assert property (mon.ov[1] [*4] |=> !ch_en_q[1])
		else $error("channel on during over voltage");
	amp_stop_a: assert property (mon.oc[2] [*4] |=> !ch_en_q[2])
		else $error("channel on during over current");
	// a restart only lengthens the gap, so with step_div_q at 3 or more a short gap is a fault
	step_gap_a: assert property ($rose(dt_step_q) |=> !dt_step_q [*3])
		else $error("dead time step too frequent");
	gap_hold_a: assert property (!bus.wr [*4] |=> $stable(gaps_q))
		else $error("gap changed without a write");
endmodule

// file: sim/host_model.sv
`timescale 1ns/1ns
module host_model
	import supv_pkg::*;
(
	// host side of the register port
	input wire logic clk,
	output supv_pkg::bus_req_t bus,
	input wire logic [7:0] rdata_q
);
	// ----------------
	// bus cycles
	// ----------------
	initial bus = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		// data stands only in the cycle after the strobe
		#1 d = rdata_q;
	endtask
endmodule

// file: sim/test_rail_enable_fault_supervisor.sv
`timescale 1ns/1ns
module test_rail_enable_fault_supervisor;
	import supv_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic chip_en = 1'b0;
	logic [2:0] ch_pin = 3'h0;
	logic link_pin = 1'b0;
	logic [2:0] pin_hist = 3'h0;
	monitor_t mon = '{ot: 1'b0, ov: 3'h0, oc: 3'h0, vin: 8'h80};
	bus_req_t bus;
	logic [7:0] rdata_q, v;
	logic config_ready_q, ldo_on_q, ldo_sel5v_q, prog_dt_q, builtin_nonoverlap_q;
	logic dt_step_q, uv_warn_pin_q;
	logic [2:0] ch_en_q;
	gap_t [2:0] gaps_q;
	logic [31:0] seed = 32'h1D2FC519;
	int bad_count = 0;
	int tests_run = 0;
	int cfg[12];
	always #20 clk = ~clk;
	// standby pin toggles at the link rate
	always begin
		repeat (4) @(posedge clk);
		link_pin <= ~link_pin;
	end
	// the standby pin reaches the regulator output two edges after it is sampled
	always @(posedge clk) begin
		pin_hist <= {pin_hist[1:0], link_pin};
	end
	rail_enable_fault_supervisor #(.OC_RESTART_CYCLES(20)) u_rail_enable_fault_supervisor (
		.clk, .rst_n, .bus, .rdata_q, .chip_en, .gpio_in({link_pin, ch_pin}), .mon,
		.config_ready_q, .ch_en_q,
		.ldo_on_q, .ldo_sel5v_q, .prog_dt_q, .builtin_nonoverlap_q, .gaps_q, .dt_step_q,
		.uv_warn_pin_q);
	host_model u_host_model (.clk, .bus, .rdata_q);
	// ----------------
	// helpers
	// ----------------
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		u_host_model.rd(a, v);
		check(v, e);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_ready;
		wt(3);
		for (int i = 0; i < 50 && config_ready_q !== 1'b1; i++) wt(1);
		check({7'h00, config_ready_q}, 8'h01);
	endtask
	function automatic logic [7:0] exp_ch(input logic [2:0] hen);
		logic [7:0] e;
		e = 8'h00;
		for (int i = 0; i < 3; i++) begin
			case (cfg[I_SRC][2*i+:2])
				SRC_ALWAYS: e[i] = 1'b1;
				SRC_PIN: e[i] = ch_pin[i];
				SRC_HOST: e[i] = hen[i];
				default: e[i] = 1'b0;
			endcase
		end
		return e;
	endfunction
	// pulse {ot, ov, oc} for four cycles, then clear the latched flags
	task automatic fault_case(input logic [6:0] f, input logic [7:0] ch, input logic [7:0] fl);
		@(posedge clk) {mon.ot, mon.ov, mon.oc} <= f;
		repeat (4) @(posedge clk);
		{mon.ot, mon.ov, mon.oc} <= 7'h00;
		wt(3);
		check({5'h00, ch_en_q}, ch);
		rdchk(A_FFLAG, fl);
		u_host_model.wr(A_FFLAG, fl);
		wt(30);
		check({5'h00, ch_en_q}, 8'h07);
	endtask
	// pulse spacing of the dead-time step against the divider value
	task automatic step_case(input logic [7:0] d);
		int n;
		u_host_model.wr(A_STEP_DIV, d);
		wt(20);
		n = 0;
		while (dt_step_q !== 1'b1 && n < 255) begin
			wt(1);
			n++;
		end
		n = 0;
		do begin
			wt(1);
			n++;
		end while (dt_step_q !== 1'b1 && n < 255);
		check(8'(n), d + 8'h01);
	endtask
	// standby regulator sources; the pin is followed through its sync delay
	task automatic ldo_case(input logic [7:0] c);
		logic e;
		u_host_model.wr(8'h02, c);
		wt(3);
		for (int i = 0; i < 8; i++) begin
			e = (c[LDO_BY_EN] && chip_en) || (c[LDO_BY_PIN] && pin_hist[2])
				|| (c[LDO_BY_HOST] && c[LDO_HOST_ON]);
			check({7'h00, ldo_on_q}, {7'h00, e});
			check({7'h00, ldo_sel5v_q}, {7'h00, c[LDO_SEL5V]});
			wt(1);
		end
	endtask
	task print_verdict;
		if (bad_count == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		print_verdict;
	end
	// ----------------
	// scenarios
	// ----------------
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		wt(8);
		check({5'h00, ch_en_q}, 8'h00);
		rdchk(A_STAT, 8'h00);
		@(posedge clk) chip_en <= 1'b1;
		wait_ready;
		rdchk(A_STAT, 8'h01);
		rdchk(A_STEP_DIV, STEP_DIV_RST);
		step_case(STEP_DIV_RST);
		step_case(8'h07);
		rdchk(A_STEP_DIV, 8'h07);
		u_host_model.wr(A_OTP_IDX, 8'h00);
		u_host_model.wr(A_OTP_PROG, 8'h39);
		u_host_model.wr(A_OTP_PROG, 8'h01);
		rdchk(A_STAT, 8'h21);
		u_host_model.wr(A_CMD, RESTART_KEY);
		wait_ready;
		cfg[I_SRC] = 'h39;
		rdchk(8'h00, 8'h39);
		for (int i = 0; i < 6; i++) begin
			v = rnd();
			@(posedge clk) ch_pin <= v[2:0];
			u_host_model.wr(8'h01, {5'h00, v[5:3]});
			wt(5);
			check({5'h00, ch_en_q}, exp_ch(v[5:3]));
		end
		for (int a = 1; a < NCFG; a++) begin
			cfg[a] = rnd() & (a == 1 ? 8'h07 : a == 2 ? 8'h1F : a == 3 ? 8'h03 : 8'hFF);
			u_host_model.wr(8'(a), 8'(cfg[a]));
			rdchk(8'(a), 8'(cfg[a]));
		end
		check({7'h00, prog_dt_q}, 8'(cfg[I_GCTL] & 1));
		check({7'h00, builtin_nonoverlap_q}, 8'(cfg[I_GCTL] & 1) ^ 8'h01);
		check({7'h00, ldo_sel5v_q}, 8'(cfg[I_LDO] & 1));
		check(gaps_q[0].lh, 8'(cfg[I_LH0]));
		check(gaps_q[2].hl, 8'(cfg[I_HL0 + 2]));
		ldo_case(8'h04);
		ldo_case(8'h19);
		ldo_case(8'h03);
		rdchk(8'h20, 8'h00);
		u_host_model.wr(8'h00, 8'h15);
		u_host_model.wr(8'h03, 8'h02);
		u_host_model.wr(8'h0A, 8'h40);
		u_host_model.wr(8'h0B, 8'h30);
		u_host_model.wr(A_FFLAG, 8'hFF);
		wt(5);
		check({5'h00, ch_en_q}, 8'h07);
		rdchk(A_VIN, 8'h80);
		@(posedge clk) mon.vin <= 8'h38;
		wt(5);
		check({7'h00, uv_warn_pin_q}, 8'h01);
		rdchk(A_WFLAG, 8'h01);
		@(posedge clk) mon.vin <= 8'h20;
		wt(5);
		check({5'h00, ch_en_q}, 8'h00);
		rdchk(A_FFLAG, 8'h01);
		@(posedge clk) mon.vin <= 8'h80;
		wt(5);
		check({5'h00, ch_en_q}, 8'h07);
		fault_case(7'h40, 8'h00, 8'h02);
		fault_case(7'h10, 8'h05, 8'h08);
		fault_case(7'h04, 8'h03, 8'h80);
		@(posedge clk) chip_en <= 1'b0;
		wt(6);
		check({5'h00, ch_en_q}, 8'h00);
		check({7'h00, config_ready_q}, 8'h00);
		check({7'h00, ldo_on_q}, 8'h00);
		print_verdict;
	end
endmodule
bind rail_enable_fault_supervisor supv_chk u_chk (.clk, .rst_n, .bus, .rdata_q, .chip_en, .mon,
	.config_ready_q, .ch_en_q, .prog_dt_q, .builtin_nonoverlap_q, .gaps_q, .dt_step_q);
